/* common/usq_defines.vh */
// Register map, field positions and reset values of the queue status block
`ifndef USQ_DEFINES_VH
`define USQ_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define USQ_ADDR_FIFO_STATUS 32'h5000117c
`define USQ_ADDR_TX_FILL_LEVEL 32'h50001180
`define USQ_ADDR_RX_FILL_LEVEL 32'h50001184
`define USQ_ADDR_SOFT_RESET_CONTROL 32'h50001188
`define USQ_ADDR_REQUEST_SEND_ALIAS 32'h5000118c
`define USQ_ADDR_LINE_CONTROL 32'h500011e0
`define USQ_ADDR_RX_TRIGGER 32'h500011e4
`define USQ_ADDR_IRQ_STATUS 32'h500011f0
`define USQ_ADDR_IRQ_CLEAR 32'h500011f4
`define USQ_ADDR_IRQ_ENABLE 32'h500011f8

// ****************************************************************
// Field positions
// ****************************************************************
`define USQ_ST_RX_FULL 4
`define USQ_ST_RX_NONEMPTY 3
`define USQ_ST_TX_EMPTY 2
`define USQ_ST_TX_NOTFULL 1
`define USQ_SR_TX_FLUSH 2
`define USQ_SR_RX_FLUSH 1
`define USQ_SR_PORT_RESET 0
`define USQ_ALIAS_RTS 0
`define USQ_LC_QUEUE_ENABLE 0
`define USQ_LC_RTS 1
`define USQ_LC_LOOPBACK 4
`define USQ_LC_AUTO_FLOW 5
`define USQ_IRQ_RX_FULL 0
`define USQ_IRQ_TX_EMPTY 1
`define USQ_IRQ_RX_TRIGGER 2

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define USQ_RST_FIFO_STATUS 16'h0006
`define USQ_RST_LEVEL 16'h0000
`define USQ_RST_ALIAS 1'b0
`define USQ_RST_LINE_CONTROL 6'h00
`define USQ_RST_RX_TRIGGER 16'h0008
`define USQ_RST_IRQ 3'h0
`define USQ_PORT_RESET_HOLD 2

`endif

/* logic/usq_queue_status.v */
// Queue status, fill levels, soft reset and request-to-send logic
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// RL1: Status bit 4 shows receive queue full
// RL2: Status bit 3 shows receive queue holds data
// RL3: Status bit 2 shows transmit queue empty, resets one
// RL4: Status bit 1 shows transmit queue not full
// RL5: Transmit level register reads current entry count
// RL6: Receive level register reads current entry count
// RL7: Reset bit 2 flushes transmit queue, self-clearing
// RL8: Reset bit 1 flushes receive queue, self-clearing
// RL9: Reset bit 0 resets whole port, async assert
// RL10: Alias bit 0 mirrors the request-to-send control
// RL11: Without auto flow, request-to-send low when set
// RL12: Auto flow gates request-to-send with receive trigger; gated here only while queue enable is also set
// RL13: Loopback holds output high, loops value back
// RL14: Queue depth is a parameter, sixteen by default
// RL15: Reserved bits and reset register read zero

`include "usq_defines.vh"

module usq_queue_status #(
  parameter DEPTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_put,
  input wire tx_take,
  input wire rx_put,
  input wire rx_take,
  output wire tx_queue_ready,
  output wire rx_queue_ready,
  output wire tx_queue_flush,
  output wire rx_queue_flush,
  output wire port_reset_n,
  output wire request_send_n,
  output wire loop_request_send,
  output wire irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;
  localparam [15:0] DEPTH_W = DEPTH[15:0];

  wire [15:0] tx_level;
  wire [15:0] rx_level;
  wire tx_clear;
  wire rx_clear;
  reg rts_bit;
  reg queue_enable;
  reg loopback;
  reg auto_flow;
  reg [15:0] rx_trigger;
  reg [2:0] irq_status;
  reg [2:0] irq_enable;
  reg [2:0] prev_event;
  reg [1:0] reset_sync;
  reg wr_hit;
  reg rd_hit;
  reg [31:0] rd_value;
  wire wr_take;
  wire [31:0] wa;
  wire [15:0] wd;
  wire [15:0] fifo_status;
  wire rx_full_flag;
  wire rx_queue_nonempty_flag;
  wire tx_queue_empty_flag;
  wire tx_queue_notfull_flag;
  wire rx_queue_full_flag;
  wire rx_over_trigger;
  wire whole_port_reset;
  wire port_rst;
  wire [2:0] event_level;
  wire [2:0] irq_clear;
  wire wr_sr;
  wire wr_alias;
  wire wr_lc;

  // ****************************************************************
  // Bus write channel
  // ****************************************************************
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign wa = s_axi_awaddr;
  assign wd[7:0] = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
  assign wd[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00;
  assign wr_sr = wr_take & (wa == `USQ_ADDR_SOFT_RESET_CONTROL);
  assign wr_alias = wr_take & (wa == `USQ_ADDR_REQUEST_SEND_ALIAS) &
    s_axi_wstrb[0];
  assign wr_lc = wr_take & (wa == `USQ_ADDR_LINE_CONTROL) &
    s_axi_wstrb[0];

  always @* begin
    case (wa)
      `USQ_ADDR_FIFO_STATUS,
      `USQ_ADDR_TX_FILL_LEVEL,
      `USQ_ADDR_RX_FILL_LEVEL,
      `USQ_ADDR_SOFT_RESET_CONTROL,
      `USQ_ADDR_REQUEST_SEND_ALIAS,
      `USQ_ADDR_LINE_CONTROL,
      `USQ_ADDR_RX_TRIGGER,
      `USQ_ADDR_IRQ_STATUS,
      `USQ_ADDR_IRQ_CLEAR,
      `USQ_ADDR_IRQ_ENABLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Soft reset
  // ****************************************************************
  // RL9: port reset request
  assign whole_port_reset = wr_sr & s_axi_wstrb[0] &
    s_axi_wdata[`USQ_SR_PORT_RESET];
  // RL9: async assert, sync release
  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_sync <= 2'b11;
    end else if (whole_port_reset) begin
      reset_sync <= 2'b00;
    end else begin
      reset_sync <= {reset_sync[0], 1'b1};
    end
  end
  assign port_rst = whole_port_reset | ~reset_sync[1];
  assign port_reset_n = ~port_rst;

  // RL7: transmit flush pulse
  assign tx_queue_flush = wr_sr & s_axi_wstrb[0] &
    s_axi_wdata[`USQ_SR_TX_FLUSH];
  // RL8: receive flush pulse
  assign rx_queue_flush = wr_sr & s_axi_wstrb[0] &
    s_axi_wdata[`USQ_SR_RX_FLUSH];

  // ****************************************************************
  // Queue occupancy
  // ****************************************************************
  // RL14: depth sets full point
  assign tx_queue_ready = tx_level != DEPTH_W;
  assign rx_queue_ready = rx_level != DEPTH_W;

  // RL7: flush empties transmit
  assign tx_clear = ~aresetn | port_rst | tx_queue_flush;
  // RL8: flush empties receive
  assign rx_clear = ~aresetn | port_rst | rx_queue_flush;

  // RL5: track transmit count
  usq_level_cnt #(
    .DEPTH(DEPTH)
  ) tx_cnt_i (
    .aclk(aclk),
    .clear(tx_clear),
    .put(tx_put),
    .take(tx_take),
    .level(tx_level)
  );

  // RL6: track receive count
  usq_level_cnt #(
    .DEPTH(DEPTH)
  ) rx_cnt_i (
    .aclk(aclk),
    .clear(rx_clear),
    .put(rx_put),
    .take(rx_take),
    .level(rx_level)
  );

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // RL1: receive full flag
  assign rx_queue_full_flag = rx_level == DEPTH_W;
  assign rx_full_flag = rx_queue_full_flag;
  // RL2: receive not-empty flag
  assign rx_queue_nonempty_flag = rx_level != 16'h0000;
  // RL3: transmit empty flag
  assign tx_queue_empty_flag = tx_level == 16'h0000;
  // RL4: transmit not-full flag
  assign tx_queue_notfull_flag = tx_level != DEPTH_W;
  // RL15: reserved status bits zero
  assign fifo_status = {11'h000, rx_full_flag, rx_queue_nonempty_flag,
    tx_queue_empty_flag, tx_queue_notfull_flag, 1'b0};

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn || port_rst) begin
      rts_bit <= `USQ_RST_ALIAS;
      {auto_flow, loopback, queue_enable} <= 3'b000;
      rx_trigger <= `USQ_RST_RX_TRIGGER;
      irq_enable <= `USQ_RST_IRQ;
    end else begin
      // RL10: alias writes control bit
      if (wr_alias)
        rts_bit <= s_axi_wdata[`USQ_ALIAS_RTS];
      else if (wr_lc)
        rts_bit <= s_axi_wdata[`USQ_LC_RTS];
      if (wr_lc) begin
        queue_enable <= s_axi_wdata[`USQ_LC_QUEUE_ENABLE];
        loopback <= s_axi_wdata[`USQ_LC_LOOPBACK];
        auto_flow <= s_axi_wdata[`USQ_LC_AUTO_FLOW];
      end
      if (wr_take && wa == `USQ_ADDR_RX_TRIGGER)
        rx_trigger <= (wd & {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}) |
          (rx_trigger & ~{{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}});
      if (wr_take && wa == `USQ_ADDR_IRQ_ENABLE && s_axi_wstrb[0])
        irq_enable <= s_axi_wdata[2:0];
    end
  end

  // ****************************************************************
  // Request to send
  // ****************************************************************
  assign rx_over_trigger = rx_level > rx_trigger;
  // RL11: active low request
  // RL12: auto flow gating
  // RL13: loopback holds high
  assign request_send_n = loopback | ~rts_bit |
    (auto_flow & queue_enable & rx_over_trigger);
  // RL13: internal loop path
  assign loop_request_send = loopback & rts_bit;

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign event_level = {rx_over_trigger, tx_queue_empty_flag,
    rx_queue_full_flag};
  assign irq_clear = (wr_take && wa == `USQ_ADDR_IRQ_CLEAR &&
    s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'h0;

  always @(posedge aclk) begin
    if (!aresetn || port_rst) begin
      irq_status <= `USQ_RST_IRQ;
      prev_event <= 3'b010;
    end else begin
      prev_event <= event_level;
      irq_status <= (irq_status & ~irq_clear) |
        (event_level & ~prev_event);
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ****************************************************************
  // Bus read channel
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_hit = 1'b1;
    rd_value = 32'h00000000;
    case (s_axi_araddr)
      `USQ_ADDR_FIFO_STATUS: rd_value = {16'h0000, fifo_status};
      `USQ_ADDR_TX_FILL_LEVEL: rd_value = {16'h0000, tx_level};
      `USQ_ADDR_RX_FILL_LEVEL: rd_value = {16'h0000, rx_level};
      // RL15: write-only reads zero
      `USQ_ADDR_SOFT_RESET_CONTROL: rd_value = 32'h00000000;
      // RL10: alias reads control bit
      `USQ_ADDR_REQUEST_SEND_ALIAS: rd_value = {31'h00000000, rts_bit};
      `USQ_ADDR_LINE_CONTROL:
        rd_value = {26'h0000000, auto_flow, loopback, 2'b00, rts_bit,
          queue_enable};
      `USQ_ADDR_RX_TRIGGER: rd_value = {16'h0000, rx_trigger};
      `USQ_ADDR_IRQ_STATUS: rd_value = {29'h00000000, irq_status};
      `USQ_ADDR_IRQ_CLEAR: rd_value = 32'h00000000;
      `USQ_ADDR_IRQ_ENABLE: rd_value = {29'h00000000, irq_enable};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // usq_queue_status

// ****************************************************************
// Queue entry counter, shared by both queues
// ****************************************************************
module usq_level_cnt #(
  parameter DEPTH = 16
) (
  input wire aclk,
  input wire clear,
  input wire put,
  input wire take,
  output reg [15:0] level
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam [15:0] DEPTH_W = DEPTH[15:0];

  reg [15:0] next_level;
  wire full;
  wire empty;
  wire can_put;
  wire can_take;

  // ****************************************************************
  // Accepted strobes
  // ****************************************************************
  // RL14: depth sets full point
  assign full = level == DEPTH_W;
  assign empty = level == 16'h0000;
  assign can_put = put & ~full;
  assign can_take = take & ~empty;

  // ****************************************************************
  // Next count
  // ****************************************************************
  always @* begin
    next_level = level;
    if (can_put && !can_take) begin
      next_level = level + 16'h0001;
    end else if (can_take && !can_put) begin
      next_level = level - 16'h0001;
    end
  end

  always @(posedge aclk) begin
    if (clear) begin
      level <= `USQ_RST_LEVEL;
    end else begin
      level <= next_level;
    end
  end

endmodule // usq_level_cnt

/* sim/usq_modem_model.sv */
// Serial peer model that sends only while request-to-send is asserted
`timescale 1ns/1ps
module usq_modem_model (
  input wire aclk,
  input wire request_send_n,
  input wire push,
  output logic rx_put
);
  // ****************************************************************
  // Peer sends a character only while request-to-send is low
  // ****************************************************************
  assign rx_put = push && (request_send_n === 1'b0);
endmodule // usq_modem_model

/* sim/usq_chk_checker.sv */
// Port checker of the queue status block
`timescale 1ns/1ps
`include "usq_defines.vh"
module usq_chk (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire tx_put,
  input wire rx_take,
  input wire tx_queue_ready,
  input wire rx_queue_ready,
  input wire tx_queue_flush,
  input wire rx_queue_flush,
  input wire port_reset_n,
  input wire request_send_n,
  input wire loop_request_send
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire sr = wr && s_axi_awaddr == `USQ_ADDR_SOFT_RESET_CONTROL;
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_txf; tx_queue_flush |-> sr && s_axi_wdata[2]; endproperty
  property p_rxf; rx_queue_flush |-> sr && s_axi_wdata[1]; endproperty
  property p_prst;
    sr && s_axi_wdata[0] |-> !port_reset_n ##1 !port_reset_n [*2]
      ##1 port_reset_n;
  endproperty
  property p_loop; loop_request_send |-> request_send_n; endproperty
  property p_txr; $fell(tx_queue_ready) |-> $past(tx_put); endproperty
  property p_rxr;
    $rose(rx_queue_ready) |-> $past(rx_take || rx_queue_flush) ||
      !port_reset_n || !$past(port_reset_n);
  endproperty
  property p_wr; wr |=> s_axi_bvalid; endproperty
  property p_rd; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  property p_bh;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_up; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_txf: assert property (p_txf) else $error("tx flush uncaused");
  a_rxf: assert property (p_rxf) else $error("rx flush uncaused");
  a_prst: assert property (p_prst) else $error("port reset span");
  a_loop: assert property (p_loop) else $error("loop rts active");
  a_txr: assert property (p_txr) else $error("tx full uncaused");
  a_rxr: assert property (p_rxr) else $error("rx ready uncaused");
  a_wr: assert property (p_wr) else $error("no write response");
  a_rd: assert property (p_rd) else $error("no read response");
  a_bh: assert property (p_bh) else $error("write response dropped");
  a_up: assert property (p_up) else $error("upper read bits set");
  c_prst: cover property (sr && s_axi_wdata[0]);
  c_full: cover property ($fell(rx_queue_ready));
  c_loop: cover property (loop_request_send);
endmodule // usq_chk

/* sim/tb.sv */
// Testbench of the queue status block
`timescale 1ns/1ps
`include "usq_defines.vh"
module tb;
  logic aclk = 0, aresetn = 0, push = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_put, irq;
  logic tx_put = 0, tx_take = 0, rx_take = 0, tx_queue_ready;
  logic rx_queue_ready, tx_queue_flush, rx_queue_flush, port_reset_n;
  logic request_send_n, loop_request_send;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  usq_queue_status #(.DEPTH(4)) usq_queue_status_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tx_put(tx_put), .tx_take(tx_take), .rx_put(rx_put), .rx_take(rx_take),
    .tx_queue_ready(tx_queue_ready), .rx_queue_ready(rx_queue_ready),
    .tx_queue_flush(tx_queue_flush), .rx_queue_flush(rx_queue_flush),
    .port_reset_n(port_reset_n), .request_send_n(request_send_n),
    .loop_request_send(loop_request_send), .irq(irq));
  usq_modem_model usq_modem_model_i (.aclk(aclk), .push(push),
    .request_send_n(request_send_n), .rx_put(rx_put));
  always #20 aclk = ~aclk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1;
    s_axi_wvalid <= 1; s_axi_bready <= 1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 0; s_axi_wvalid <= 0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    bs = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task rdr(input logic [31:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata; rs = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task rc(input string n, input logic [31:0] a, input logic [31:0] e);
    rdr(a);
    chk(n, e, rd);
  endtask
  task q(input logic [3:0] p, input int k);
    repeat (k) begin
      {tx_put, tx_take, rx_take, push} <= p;
      @(posedge aclk);
      {tx_put, tx_take, rx_take, push} <= 0;
      @(posedge aclk);
    end
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rc("status", `USQ_ADDR_FIFO_STATUS, 32'h6);
    rc("txlvl", `USQ_ADDR_TX_FILL_LEVEL, 0);
    rc("rxlvl", `USQ_ADDR_RX_FILL_LEVEL, 0);
    rc("srr", `USQ_ADDR_SOFT_RESET_CONTROL, 0);
    rc("alias", `USQ_ADDR_REQUEST_SEND_ALIAS, 0);
    rdr(32'h50001190);
    chk("unmapped", 32'h2, {30'h0, rs});
    chk("unmapped_d", 0, rd);
    wr(32'h50001190, 0);
    chk("wresp", 32'h2, {30'h0, bs});
    $display("test reset done");
    q(4'h8, 1);
    rc("status1", `USQ_ADDR_FIFO_STATUS, 32'h2);
    q(4'h8, 4);
    rc("txfull", `USQ_ADDR_FIFO_STATUS, 32'h0);
    chk("txrdy", 0, tx_queue_ready);
    rc("txmax", `USQ_ADDR_TX_FILL_LEVEL, 4);
    q(4'h4, 1);
    rc("txtake", `USQ_ADDR_TX_FILL_LEVEL, 3);
    $display("test tx done");
    wr(`USQ_ADDR_REQUEST_SEND_ALIAS, 1);
    chk("wok", 0, {30'h0, bs});
    rc("lc", `USQ_ADDR_LINE_CONTROL, 32'h2);
    chk("rtsn", 0, request_send_n);
    q(4'h1, 5);
    rc("rxfull", `USQ_ADDR_FIFO_STATUS, 32'h1a);
    chk("rxrdy", 0, rx_queue_ready);
    rc("rxlvl4", `USQ_ADDR_RX_FILL_LEVEL, 4);
    $display("test rx done");
    wr(`USQ_ADDR_SOFT_RESET_CONTROL, 32'h6);
    rc("flush", `USQ_ADDR_FIFO_STATUS, 32'h6);
    rc("rxfl", `USQ_ADDR_RX_FILL_LEVEL, 0);
    chk("rxrdy2", 1, rx_queue_ready);
    rc("srr0", `USQ_ADDR_SOFT_RESET_CONTROL, 0);
    $display("test flush done");
    wr(`USQ_ADDR_RX_TRIGGER, 2);
    wr(`USQ_ADDR_LINE_CONTROL, 32'h23);
    q(4'h1, 2);
    rc("rxne", `USQ_ADDR_FIFO_STATUS, 32'he);
    chk("rtsn2", 0, request_send_n);
    q(4'h1, 1);
    chk("rtsn3", 1, request_send_n);
    q(4'h1, 1);
    rc("held", `USQ_ADDR_RX_FILL_LEVEL, 3);
    q(4'h2, 1);
    chk("rtsn4", 0, request_send_n);
    wr(`USQ_ADDR_LINE_CONTROL, 32'h12);
    chk("loop", 1, request_send_n);
    chk("loopin", 1, loop_request_send);
    $display("test flow done");
    wr(`USQ_ADDR_LINE_CONTROL, 32'h3);
    wr(`USQ_ADDR_IRQ_ENABLE, 0);
    q(4'h1, 2);
    chk("masked", 0, irq);
    wr(`USQ_ADDR_IRQ_ENABLE, 1);
    chk("irq", 1, irq);
    wr(`USQ_ADDR_IRQ_CLEAR, 1);
    chk("irqclr", 0, irq);
    rc("irqst", `USQ_ADDR_IRQ_STATUS, 32'h6);
    $display("test irq done");
    wr(`USQ_ADDR_SOFT_RESET_CONTROL, 1);
    repeat (3) @(posedge aclk);
    rc("prst", `USQ_ADDR_RX_FILL_LEVEL, 0);
    rc("prsta", `USQ_ADDR_REQUEST_SEND_ALIAS, 0);
    rc("prste", `USQ_ADDR_IRQ_ENABLE, 0);
    rc("prsts", `USQ_ADDR_FIFO_STATUS, 32'h6);
    $display("test port reset done");
    conclude();
  end
endmodule // tb
bind usq_queue_status usq_chk usq_chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .tx_put(tx_put), .rx_take(rx_take), .tx_queue_ready(tx_queue_ready),
  .rx_queue_ready(rx_queue_ready), .tx_queue_flush(tx_queue_flush),
  .rx_queue_flush(rx_queue_flush), .port_reset_n(port_reset_n),
  .request_send_n(request_send_n), .loop_request_send(loop_request_send));
